//--- hdl/rx_polarity_error_fsm.sv
// receive error polarity control for the quality layer of a serial link
// assumes all inputs come from logic on clk_sys; the transmit scheduler
// takes a pending ACK or NACK word with a one-cycle taken pulse
//
// Notes on behaviour
// - a four-state machine alone decides the receive polarity flag
// - cold reset, warm reset or remote flush force valid positive from anywhere
// - valid positive presents a positive polarity flag
// - valid positive plus NACK request goes to error negative before the NACK
// - valid negative presents a negative polarity flag
// - valid negative plus NACK request goes to error positive before the NACK
// - error positive presents a positive polarity flag
// - error positive plus ACK request goes to valid positive before the ACK
// - error positive, positive out-of-sequence frame goes to error negative first
// - error negative presents a negative polarity flag
// - error negative plus ACK request goes to valid negative before the ACK
// - error negative, negative out-of-sequence frame goes to error positive first
// - ACK words carry the held polarity, NACK words the opposite one
// - in valid positive ACKs go positive; a NACK from there goes positive
// - a good frame, FCT or FULL with no sequence or CRC error and no same-cycle NACK cause requests an ACK
// - a NACK carries the receive sequence count with the flag inverted
// - a new ACK request cancels a pending NACK, and the reverse
module rx_polarity_error_fsm (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cold_reset_cmd,
  input wire logic warm_reset_cmd,
  input wire logic remote_flush,
  input wire logic rx_frame_valid,
  input wire logic rx_frame_pol,
  input wire logic rx_frame_seq_err,
  input wire logic rx_frame_crc_err,
  input wire logic rx_nack_cause,
  input wire logic [rx_err_pkg::SEQ_CNT_W-1:0] rx_seq_count,
  input wire logic tx_word_strobe,
  input wire logic tx_ack_taken,
  input wire logic tx_nack_taken,
  output logic ack_send_valid,
  output logic nack_send_valid,
  output logic [rx_err_pkg::SEQ_NUM_W-1:0] ack_seq_num,
  output logic [rx_err_pkg::SEQ_NUM_W-1:0] nack_seq_num,
  output logic rx_pol_flag,
  output logic [1:0] rx_err_state
);

  rx_err_if ctl_bus ();

  logic flush_any;
  logic frame_good;
  logic frame_bad;
  logic ack_req;
  logic nack_req;
  logic ack_sent;
  logic nack_sent;
  logic ack_pend_reg;
  logic nack_pend_reg;
  logic [3:0] ack_gap_reg;
  logic [rx_err_pkg::SEQ_NUM_W-1:0] ack_seq_reg;
  logic [rx_err_pkg::SEQ_NUM_W-1:0] nack_seq_reg;
  logic pol_flag_reg;
  logic pol_next;

  // any of the three restart conditions
  assign flush_any = cold_reset_cmd | warm_reset_cmd | remote_flush;

  // classify a received data frame, broadcast frame, FCT or FULL
  assign frame_good = rx_frame_valid & ~rx_frame_seq_err & ~rx_frame_crc_err;
  assign frame_bad = rx_frame_valid & (rx_frame_seq_err | rx_frame_crc_err);

  // a NACK cause beats a good frame in the same cycle: the error must be reported
  assign nack_req = rx_nack_cause | frame_bad;
  assign ack_req = frame_good & ~nack_req;

  // drive the core; flush priority lives in the core's next-state logic
  assign ctl_bus.ack_req = ack_req;
  assign ctl_bus.nack_req = nack_req;
  assign ctl_bus.flush_any = flush_any;
  assign ctl_bus.seq_err_evt = rx_frame_valid & rx_frame_seq_err;
  assign ctl_bus.seq_err_pol = rx_frame_pol;

  rx_err_state_core u_core (
    .clk_sys(clk_sys),
    .srst(srst),
    .ctl(ctl_bus.core)
  );

  // polarity of the state being entered, so words built now match it
  assign pol_next = rx_err_pkg::pol_of(ctl_bus.state_next);

  // handshake towards the transmit scheduler
  assign ack_send_valid = ack_pend_reg & (ack_gap_reg == rx_err_pkg::ACK_GAP_NONE);
  assign nack_send_valid = nack_pend_reg;
  assign ack_sent = ack_send_valid & tx_ack_taken;
  assign nack_sent = nack_send_valid & tx_nack_taken;

  // pending ACK: a new request wins over a same-cycle send, a NACK cancels it
  always_ff @(posedge clk_sys) begin
    if (srst || flush_any) begin
      ack_pend_reg <= 1'h0;
    end else if (nack_req) begin
      ack_pend_reg <= 1'h0;
    end else if (ack_req) begin
      ack_pend_reg <= 1'h1;
    end else if (ack_sent) begin
      ack_pend_reg <= 1'h0;
    end
  end

  // pending NACK: a new request wins over a same-cycle send, an ACK cancels it
  always_ff @(posedge clk_sys) begin
    if (srst || flush_any) begin
      nack_pend_reg <= 1'h0;
    end else if (nack_req) begin
      nack_pend_reg <= 1'h1;
    end else if (ack_req) begin
      nack_pend_reg <= 1'h0;
    end else if (nack_sent) begin
      nack_pend_reg <= 1'h0;
    end
  end

  // spacing between ACKs, counted in transmitted words; a later request
  // simply waits, it is not dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_gap_reg <= rx_err_pkg::ACK_GAP_NONE;
    end else if (ack_sent) begin
      ack_gap_reg <= rx_err_pkg::ACK_GAP_WORDS;
    end else if (tx_word_strobe && ack_gap_reg != rx_err_pkg::ACK_GAP_NONE) begin
      ack_gap_reg <= ack_gap_reg - 4'h1;
    end
  end

  // sequence numbers are rebuilt every cycle from the state being entered,
  // so a word raised by a request already shows the post-transition polarity
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_seq_reg <= rx_err_pkg::SEQ_NUM_RST;
      nack_seq_reg <= rx_err_pkg::SEQ_NUM_RST;
    end else begin
      ack_seq_reg <= {pol_next, rx_seq_count};
      nack_seq_reg <= {~pol_next, rx_seq_count};
    end
  end

  // registered copy of the polarity flag
  always_ff @(posedge clk_sys) begin
    if (srst) pol_flag_reg <= rx_err_pkg::POL_POS;
    else pol_flag_reg <= pol_next;
  end

  assign ack_seq_num = ack_seq_reg;
  assign nack_seq_num = nack_seq_reg;
  assign rx_pol_flag = pol_flag_reg;
  assign rx_err_state = ctl_bus.state;

  // checks on the machine and on the words it shapes

  force_vp_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    flush_any |=> rx_err_state == rx_err_pkg::ST_VALID_POS && !ack_pend_reg && !nack_pend_reg
  ) else $error("restart did not give valid positive");

  flush_wins_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (flush_any && (ack_req || nack_req || rx_frame_seq_err))
      |=> rx_err_state == rx_err_pkg::ST_VALID_POS && rx_pol_flag == rx_err_pkg::POL_POS
  ) else $error("same-cycle event beat a restart");

  vp_flag_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    rx_err_state == rx_err_pkg::ST_VALID_POS |-> rx_pol_flag == rx_err_pkg::POL_POS
  ) else $error("valid positive shows negative flag");

  vn_flag_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    rx_err_state == rx_err_pkg::ST_VALID_NEG |-> rx_pol_flag == rx_err_pkg::POL_NEG
  ) else $error("valid negative shows positive flag");

  ep_flag_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    rx_err_state == rx_err_pkg::ST_ERR_POS |-> rx_pol_flag == rx_err_pkg::POL_POS
  ) else $error("error positive shows negative flag");

  en_flag_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    rx_err_state == rx_err_pkg::ST_ERR_NEG |-> rx_pol_flag == rx_err_pkg::POL_NEG
  ) else $error("error negative shows positive flag");

  vp_nack_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_VALID_POS && nack_req && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_ERR_NEG && nack_send_valid
        && nack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_err_pkg::POL_POS
  ) else $error("NACK from valid positive mishandled");

  vn_nack_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_VALID_NEG && nack_req && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_ERR_POS && nack_send_valid
        && nack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_err_pkg::POL_NEG
  ) else $error("NACK from valid negative mishandled");

  ep_ack_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_ERR_POS && ack_req && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_VALID_POS && ack_pend_reg
        && ack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_err_pkg::POL_POS
  ) else $error("ACK from error positive mishandled");

  ep_seqerr_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_ERR_POS && rx_frame_valid && rx_frame_seq_err
      && rx_frame_pol == rx_err_pkg::POL_POS && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_ERR_NEG
        && nack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_err_pkg::POL_POS
  ) else $error("sequence error in error positive mishandled");

  en_ack_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_ERR_NEG && ack_req && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_VALID_NEG && ack_pend_reg
        && ack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_err_pkg::POL_NEG
  ) else $error("ACK from error negative mishandled");

  en_seqerr_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_ERR_NEG && rx_frame_valid && rx_frame_seq_err
      && rx_frame_pol == rx_err_pkg::POL_NEG && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_ERR_POS
        && nack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_err_pkg::POL_NEG
  ) else $error("sequence error in error negative mishandled");

  word_pol_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    !$past(srst) |-> ack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_pol_flag
      && nack_seq_num[rx_err_pkg::SEQ_POL_BIT] != rx_pol_flag
  ) else $error("word polarity does not follow the flag");

  vp_words_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_VALID_POS && ack_send_valid)
      |-> ack_seq_num[rx_err_pkg::SEQ_POL_BIT] == rx_err_pkg::POL_POS
  ) else $error("ACK in valid positive not positive");

  ack_request_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (frame_good && !nack_req && !flush_any) |=> ack_pend_reg && !nack_pend_reg
  ) else $error("good frame did not request an ACK");

  nack_count_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    nack_send_valid && !$past(srst)
      |-> nack_seq_num[rx_err_pkg::SEQ_CNT_W-1:0] == $past(rx_seq_count)
  ) else $error("NACK count does not match the receive counter");

  nack_cancel_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (nack_req && !flush_any) |=> !ack_send_valid ##1 ($past(ack_req) || !ack_send_valid)
  ) else $error("NACK request left an ACK pending");

  ack_spacing_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    ack_sent |=> !ack_send_valid [*2]
  ) else $error("second ACK offered too soon");

  // ACK spacing reload, holds, wrong-polarity errors and request priority; a broken guard shows up here first
  ack_gap_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    ack_sent |=> ack_gap_reg == rx_err_pkg::ACK_GAP_WORDS
  ) else $error("ACK spacing not reloaded");

  ep_wrongpol_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_ERR_POS && rx_frame_valid && rx_frame_seq_err
      && rx_frame_pol == rx_err_pkg::POL_NEG && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_ERR_POS && nack_send_valid
  ) else $error("negative sequence error moved error positive");

  en_wrongpol_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_ERR_NEG && rx_frame_valid && rx_frame_seq_err
      && rx_frame_pol == rx_err_pkg::POL_POS && !flush_any)
      |=> rx_err_state == rx_err_pkg::ST_ERR_NEG && nack_send_valid
  ) else $error("positive sequence error moved error negative");

  vp_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_VALID_POS && !nack_req)
      |=> rx_err_state == rx_err_pkg::ST_VALID_POS
  ) else $error("valid positive left without a NACK request");

  en_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rx_err_state == rx_err_pkg::ST_ERR_NEG && !ack_req && !flush_any
      && !(rx_frame_valid && rx_frame_seq_err && rx_frame_pol == rx_err_pkg::POL_NEG))
      |=> rx_err_state == rx_err_pkg::ST_ERR_NEG
  ) else $error("error negative left without cause");

  nack_wins_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (frame_good && rx_nack_cause && !flush_any) |=> nack_send_valid && !ack_pend_reg
  ) else $error("good frame beat a same-cycle NACK cause");

  pend_excl_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    !(ack_pend_reg && nack_pend_reg)
  ) else $error("ACK and NACK pending together");

endmodule // rx_polarity_error_fsm

//--- hdl/rx_err_pkg.sv
// constants and types for the receive error polarity machine
// assumes one system clock and a 7-bit receive sequence counter held outside
package rx_err_pkg;

  // the four states; bit 0 set means the polarity flag is negative
  typedef enum logic [1:0] {
    ST_VALID_POS = 2'h0,
    ST_VALID_NEG = 2'h1,
    ST_ERR_POS = 2'h2,
    ST_ERR_NEG = 2'h3
  } rx_err_state_t;

  localparam logic POL_POS = 1'h0;
  localparam logic POL_NEG = 1'h1;

  localparam int SEQ_CNT_W = 7;
  localparam int SEQ_NUM_W = 8;
  // polarity sits above the count in an outgoing sequence number
  localparam int SEQ_POL_BIT = 7;
  localparam logic [SEQ_NUM_W-1:0] SEQ_NUM_RST = 8'h00;

  // words that must pass after an ACK before the next one may go
  localparam logic [3:0] ACK_GAP_WORDS = 4'hF;
  localparam logic [3:0] ACK_GAP_NONE = 4'h0;

  // polarity flag implied by a state, and nothing else
  function automatic logic pol_of(input rx_err_state_t s);
    logic p;
    p = POL_POS;
    case (s)
      ST_VALID_POS: p = POL_POS;
      ST_VALID_NEG: p = POL_NEG;
      ST_ERR_POS: p = POL_POS;
      ST_ERR_NEG: p = POL_NEG;
      default: p = POL_POS;
    endcase
    return p;
  endfunction

endpackage

//--- hdl/rx_err_if.sv
// bundle between the request logic and the receive error state core
// assumes both ends run on the same system clock
interface rx_err_if;
  logic ack_req;
  logic nack_req;
  logic flush_any;
  logic seq_err_evt;
  logic seq_err_pol;
  rx_err_pkg::rx_err_state_t state;
  rx_err_pkg::rx_err_state_t state_next;

  modport ctrl (
    output ack_req,
    output nack_req,
    output flush_any,
    output seq_err_evt,
    output seq_err_pol,
    input state,
    input state_next
  );

  modport core (
    input ack_req,
    input nack_req,
    input flush_any,
    input seq_err_evt,
    input seq_err_pol,
    output state,
    output state_next
  );
endinterface

//--- hdl/rx_err_state_core.sv
// four-state receive error machine that sets the receive polarity flag
// assumes ack_req and nack_req never arrive together (the caller resolves it)
module rx_err_state_core (
  input wire logic clk_sys,
  input wire logic srst,
  rx_err_if.core ctl
);

  rx_err_pkg::rx_err_state_t state_reg;
  rx_err_pkg::rx_err_state_t state_next;

  // next state; a reset or flush overrides every other event
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rx_err_pkg::ST_VALID_POS: begin
        if (ctl.nack_req) state_next = rx_err_pkg::ST_ERR_NEG;
      end
      rx_err_pkg::ST_VALID_NEG: begin
        if (ctl.nack_req) state_next = rx_err_pkg::ST_ERR_POS;
      end
      rx_err_pkg::ST_ERR_POS: begin
        if (ctl.ack_req) begin
          state_next = rx_err_pkg::ST_VALID_POS;
        end else if (ctl.seq_err_evt && ctl.seq_err_pol == rx_err_pkg::POL_POS) begin
          state_next = rx_err_pkg::ST_ERR_NEG;
        end
      end
      rx_err_pkg::ST_ERR_NEG: begin
        if (ctl.ack_req) begin
          state_next = rx_err_pkg::ST_VALID_NEG;
        end else if (ctl.seq_err_evt && ctl.seq_err_pol == rx_err_pkg::POL_NEG) begin
          state_next = rx_err_pkg::ST_ERR_POS;
        end
      end
      default: state_next = rx_err_pkg::ST_VALID_POS;
    endcase
    if (ctl.flush_any) state_next = rx_err_pkg::ST_VALID_POS;
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) state_reg <= rx_err_pkg::ST_VALID_POS;
    else state_reg <= state_next;
  end

  assign ctl.state = state_reg;
  assign ctl.state_next = state_next;

  // error positive is left only by an ACK request, a flush or a matching sequence error
  err_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (state_reg == rx_err_pkg::ST_ERR_POS && !ctl.ack_req && !ctl.flush_any
      && !ctl.seq_err_evt) |=> state_reg == rx_err_pkg::ST_ERR_POS
  ) else $error("error positive state left without cause");

  // valid negative holds until a NACK request or a flush
  valid_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    (state_reg == rx_err_pkg::ST_VALID_NEG && !ctl.nack_req && !ctl.flush_any)
      |=> $stable(state_reg)
  ) else $error("valid negative state left without cause");

endmodule // rx_err_state_core

//--- sim/tx_sched_model.sv
// transmit scheduler model standing where the link word scheduler sits
// assumes the block's ack/nack valid outputs on clk_sys; stall freezes all words
module tx_sched_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic stall,
  input wire logic ack_send_valid,
  input wire logic nack_send_valid,
  output logic tx_word_strobe,
  output logic tx_ack_taken,
  output logic tx_nack_taken
);
  timeunit 1ns;
  timeprecision 1ps;

  // one word per cycle unless stalled; a take follows one cycle after valid is seen,
  // so a request cancelled meanwhile is met by a take pulse that must be ignored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_word_strobe <= 1'h0;
      tx_ack_taken <= 1'h0;
      tx_nack_taken <= 1'h0;
    end else begin
      tx_word_strobe <= !stall;
      tx_ack_taken <= ack_send_valid && !stall && !tx_ack_taken;
      tx_nack_taken <= nack_send_valid && !stall && !tx_nack_taken;
    end
  end
endmodule // tx_sched_model

//--- sim/tb.sv
// self-checking bench for the receive error polarity machine
// assumes the scheduler model answers ack/nack words; inputs change on falling edges
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, srst, cold_reset_cmd, warm_reset_cmd, remote_flush;
  logic rx_frame_valid, rx_frame_pol, rx_frame_seq_err, rx_frame_crc_err, rx_nack_cause;
  logic [rx_err_pkg::SEQ_CNT_W-1:0] rx_seq_count;
  logic tx_word_strobe, tx_ack_taken, tx_nack_taken, stall;
  logic ack_send_valid, nack_send_valid, rx_pol_flag;
  logic [rx_err_pkg::SEQ_NUM_W-1:0] ack_seq_num, nack_seq_num;
  logic [1:0] rx_err_state;
  int n_errors, cmp_count;

  rx_polarity_error_fsm dut (.clk_sys(clk_sys), .srst(srst), .cold_reset_cmd(cold_reset_cmd),
    .warm_reset_cmd(warm_reset_cmd), .remote_flush(remote_flush),
    .rx_frame_valid(rx_frame_valid), .rx_frame_pol(rx_frame_pol),
    .rx_frame_seq_err(rx_frame_seq_err), .rx_frame_crc_err(rx_frame_crc_err),
    .rx_nack_cause(rx_nack_cause), .rx_seq_count(rx_seq_count),
    .tx_word_strobe(tx_word_strobe), .tx_ack_taken(tx_ack_taken),
    .tx_nack_taken(tx_nack_taken), .ack_send_valid(ack_send_valid),
    .nack_send_valid(nack_send_valid), .ack_seq_num(ack_seq_num),
    .nack_seq_num(nack_seq_num), .rx_pol_flag(rx_pol_flag), .rx_err_state(rx_err_state));

  tx_sched_model sched (.clk_sys(clk_sys), .srst(srst), .stall(stall),
    .ack_send_valid(ack_send_valid), .nack_send_valid(nack_send_valid),
    .tx_word_strobe(tx_word_strobe), .tx_ack_taken(tx_ack_taken),
    .tx_nack_taken(tx_nack_taken));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one cycle of receive events, entered and left on a falling edge; r = {cold, warm, flush}
  task automatic ev(input logic fv, input logic pol, input logic se, input logic ce,
                    input logic nc, input logic [2:0] r);
    rx_frame_valid = fv;
    rx_frame_pol = pol;
    rx_frame_seq_err = se;
    rx_frame_crc_err = ce;
    rx_nack_cause = nc;
    {cold_reset_cmd, warm_reset_cmd, remote_flush} = r;
    @(negedge clk_sys);
    {rx_frame_valid, rx_frame_pol, rx_frame_seq_err, rx_frame_crc_err, rx_nack_cause} = 5'h00;
    {cold_reset_cmd, warm_reset_cmd, remote_flush} = 3'h0;
  endtask

  task automatic st(input rx_err_pkg::rx_err_state_t s, input logic p);
    chk({6'h00, rx_err_state}, {6'h00, s});
    chk({7'h00, rx_pol_flag}, {7'h00, p});
  endtask

  // bounded wait until neither word is pending
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && (ack_send_valid !== 1'h0 || nack_send_valid !== 1'h0); i++) begin
      @(negedge clk_sys);
    end
    if (i >= 40) begin
      n_errors++;
      $display("CHECK FAILED t=%0t pending words never taken %h %h", $time, ack_send_valid,
               nack_send_valid);
      end_sim();
    end
  endtask

  task automatic t_reset_vals();
    st(rx_err_pkg::ST_VALID_POS, rx_err_pkg::POL_POS);
    chk({6'h00, ack_send_valid, nack_send_valid}, 8'h00);
    chk(ack_seq_num, 8'h00);
  endtask

  task automatic t_ack_vp();
    rx_seq_count = 7'h2A;
    ev(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0);
    chk({7'h00, ack_send_valid}, 8'h01);
    chk(ack_seq_num, {rx_err_pkg::POL_POS, 7'h2A});
    st(rx_err_pkg::ST_VALID_POS, rx_err_pkg::POL_POS);
    wait_idle();
  endtask

  // walk every transition back to back, at the top count value
  task automatic t_cycle();
    rx_seq_count = 7'h7F;
    ev(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 3'h0);
    st(rx_err_pkg::ST_ERR_NEG, rx_err_pkg::POL_NEG);
    chk({7'h00, nack_send_valid}, 8'h01);
    chk(nack_seq_num, {rx_err_pkg::POL_POS, 7'h7F});
    ev(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0);
    st(rx_err_pkg::ST_VALID_NEG, rx_err_pkg::POL_NEG);
    chk(ack_seq_num, {rx_err_pkg::POL_NEG, 7'h7F});
    ev(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 3'h0);
    st(rx_err_pkg::ST_ERR_POS, rx_err_pkg::POL_POS);
    chk({6'h00, ack_send_valid, nack_send_valid}, 8'h01);
    chk(nack_seq_num, {rx_err_pkg::POL_NEG, 7'h7F});
    ev(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 3'h0);
    st(rx_err_pkg::ST_ERR_POS, rx_err_pkg::POL_POS);
    ev(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 3'h0);
    st(rx_err_pkg::ST_ERR_NEG, rx_err_pkg::POL_NEG);
    chk(nack_seq_num, {rx_err_pkg::POL_POS, 7'h7F});
    ev(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 3'h0);
    st(rx_err_pkg::ST_ERR_NEG, rx_err_pkg::POL_NEG);
    chk({7'h00, nack_send_valid}, 8'h01);
    ev(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 3'h0);
    st(rx_err_pkg::ST_ERR_POS, rx_err_pkg::POL_POS);
    ev(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0);
    st(rx_err_pkg::ST_VALID_POS, rx_err_pkg::POL_POS);
    chk(ack_seq_num, {rx_err_pkg::POL_POS, 7'h7F});
    wait_idle();
  endtask

  // scheduler stalled so requests stay pending and can cancel each other
  task automatic t_cancel();
    repeat (48) @(negedge clk_sys);
    stall = 1'h1;
    rx_seq_count = 7'h00;
    ev(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0);
    chk({6'h00, ack_send_valid, nack_send_valid}, 8'h02);
    ev(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 3'h0);
    chk({6'h00, ack_send_valid, nack_send_valid}, 8'h01);
    ev(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0);
    chk({6'h00, ack_send_valid, nack_send_valid}, 8'h02);
    chk(ack_seq_num, {rx_err_pkg::POL_NEG, 7'h00});
    ev(1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0);
    st(rx_err_pkg::ST_ERR_POS, rx_err_pkg::POL_POS);
    chk({6'h00, ack_send_valid, nack_send_valid}, 8'h01);
    stall = 1'h0;
    wait_idle();
  endtask

  // each reset source, coinciding with a nack request, wins and empties the pending NACK
  task automatic t_flush();
    logic [2:0] src;
    for (int i = 0; i < 3; i++) begin
      src = 3'h1 << i;
      ev(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 3'h0);
      ev(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, src);
      st(rx_err_pkg::ST_VALID_POS, rx_err_pkg::POL_POS);
      chk({7'h00, nack_send_valid}, 8'h00);
    end
  endtask

  initial begin
    n_errors = 0;
    cmp_count = 0;
    stall = 1'h0;
    rx_seq_count = 7'h00;
    {rx_frame_valid, rx_frame_pol, rx_frame_seq_err, rx_frame_crc_err, rx_nack_cause} = 5'h00;
    {cold_reset_cmd, warm_reset_cmd, remote_flush} = 3'h0;
    srst = 1'h1;
    repeat (16) @(negedge clk_sys);
    srst = 1'h0;
    @(negedge clk_sys);
    t_reset_vals();
    t_ack_vp();
    t_cycle();
    t_cancel();
    t_flush();
    end_sim();
  end
endmodule // tb
